// *** test/lic_phy_model.sv ***
// phy model: pulses bus reset completion with an assigned node number
// assumes the bench raises go for one cycle off the rising edge
`timescale 1ns/1ns
module lic_phy_model (
    // control from bench
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [5:0] num,
    // towards the link
    output logic            bus_reset_done,
    output logic      [5:0] phy_node_num
);
    logic [5:0] num_q;
    always_ff @(posedge clk) begin
        bus_reset_done <= go;
        num_q          <= num;
    end
    // number is only valid with the pulse, garbage otherwise
    assign phy_node_num = bus_reset_done ? num_q : ~num_q;
endmodule // lic_phy_model

// *** test/lic_properties.sv ***
// checker of the host port, node identity and interrupt line
// assumes it is bound to lic_top
`timescale 1ns/1ns
module lic_properties
    import lic_pkg::*;
(
    input wire logic        clk, rst, reg_wr, reg_rd, bus_reset_done, host_irq_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata, reg_rdata, link_control,
    input wire logic [5:0]  phy_node_num, node_num,
    input wire logic [9:0]  bus_num
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==================================================================
    // assertions
    chk_bus_forced: assert property (bus_reset_done |=> bus_num == 10'h3ff)
        else $error("bus number not forced");
    chk_node_loaded: assert property (bus_reset_done |=> node_num == $past(phy_node_num))
        else $error("node number not loaded");
    chk_codes_fixed: assert property (reg_rd && reg_addr == OFF_NODE_IDENTITY
        |=> reg_rdata[15:0] == {PART_CODE, REVISION_CODE}) else $error("bad codes");
    chk_unmapped_zero: assert property (reg_rd && reg_addr == 12'h0fc |=> reg_rdata == 0)
        else $error("unmapped read not zero");
    chk_quadlet_store: assert property (reg_wr && reg_addr == OFF_LINK_CONTROL
        |=> link_control == $past(reg_wdata)) else $error("control not stored");
    chk_irq_latched: assert property (!host_irq_n && !reg_wr |=> !host_irq_n)
        else $error("interrupt dropped without a write");
    chk_irq_release: assert property ($rose(host_irq_n) |-> $past(reg_wr))
        else $error("interrupt released without a write");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    chk_glob_summary: assert property (reg_rd && reg_addr == OFF_GLOBAL_CSR
        |=> (reg_rdata[3:0] != 4'h0) == !$past(host_irq_n)) else $error("summary and line differ");
    chk_glob_upper: assert property (reg_rd && reg_addr == OFF_GLOBAL_CSR
        |=> reg_rdata[31:4] == 28'h0000000) else $error("global upper bits not zero");
    cover property (bus_reset_done);
    cover property (bus_reset_done && reg_wr && reg_addr == OFF_NODE_IDENTITY);
    cover property ($fell(host_irq_n));
    cover property ($rose(host_irq_n));
endmodule // lic_properties
bind lic_top lic_properties i_lic_properties (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .bus_reset_done(bus_reset_done), .host_irq_n(host_irq_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .link_control(link_control), .phy_node_num(phy_node_num), .node_num(node_num),
    .bus_num(bus_num));

// *** test/lic_top_tb.sv ***
// bench for lic_top: register calls with expected values
// assumes lic_phy_model and the bound checker
`timescale 1ns/1ns
module lic_top_tb;
    import lic_pkg::*;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0;
    logic [11:0] reg_addr = 0, sa;
    logic [31:0] reg_wdata = 0;
    logic [5:0]  num = 0;
    logic [31:0] ev [4] = '{default: 0};
    wire  [31:0] reg_rdata, link_control;
    wire  [9:0]  bus_num;
    wire  [5:0]  node_num, phy_node_num;
    wire         bus_reset_done, host_irq_n;
    int          fails = 0, checks_done = 0;
    localparam logic [15:0] CODES = {PART_CODE, REVISION_CODE};
    always #5 clk = ~clk;
    lic_phy_model i_lic_phy_model (.clk(clk), .go(go), .num(num),
        .bus_reset_done(bus_reset_done), .phy_node_num(phy_node_num));
    lic_top i_lic_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .link_phy_event(ev[0]), .av_transmit_event(ev[1]), .av_receive_event(ev[2]),
        .async_event(ev[3]), .bus_reset_done(bus_reset_done), .phy_node_num(phy_node_num),
        .bus_num(bus_num), .node_num(node_num), .link_control(link_control),
        .host_irq_n(host_irq_n));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1;
        @(negedge clk); reg_wr = 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge clk); reg_addr = a; reg_rd = 1;
        @(negedge clk); reg_rd = 0; chk(reg_rdata, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #20000; fails++; complete_run;
    end
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        rd(OFF_NODE_IDENTITY, {10'h3ff, 6'h3f, CODES});
        wr(OFF_NODE_IDENTITY, 32'h12345678);
        rd(OFF_NODE_IDENTITY, {16'h1234, CODES});
        @(negedge clk); num = 6'h05; go = 1;
        @(negedge clk); go = 0;
        rd(OFF_NODE_IDENTITY, {10'h3ff, 6'h05, CODES});
        chk(32'(bus_num), 32'h000003ff);
        chk(32'(node_num), 32'h00000005);
        // bus reset completion and a host write land on the same edge
        @(negedge clk); num = 6'h2a; go = 1;
        @(negedge clk); go = 0; reg_addr = OFF_NODE_IDENTITY; reg_wdata = 32'h00010000; reg_wr = 1;
        @(negedge clk); reg_wr = 0;
        chk(32'(node_num), 32'h0000002a);
        chk(32'(bus_num), 32'h000003ff);
        wr(OFF_LINK_CONTROL, 32'ha5a50f0f);
        rd(OFF_LINK_CONTROL, 32'ha5a50f0f);
        wr(OFF_GLOBAL_CSR, 32'h0000000f);
        rd(OFF_GLOBAL_CSR, 32'h0);
        rd(12'h0fc, 32'h0);
        for (int i = 0; i < 4; i++) begin
            sa = OFF_LINK_PHY_STAT + 12'(8 * i);
            wr(sa + 12'h004, 32'h1);
            @(negedge clk); ev[i] = 32'h3;
            @(negedge clk); ev[i] = 32'h0;
            chk(32'(host_irq_n), 32'h0);
            rd(OFF_GLOBAL_CSR, 32'h1 << i);
            wr(sa, 32'h1);
            rd(sa, 32'h2);
            chk(32'(host_irq_n), 32'h1);
            rd(OFF_GLOBAL_CSR, 32'h0);
            wr(sa, 32'h2);
        end
        // event and clear on the same edge: the event wins
        @(negedge clk); reg_addr = OFF_LINK_PHY_STAT; reg_wdata = 32'h1; reg_wr = 1; ev[0] = 32'h1;
        @(negedge clk); reg_wr = 0; ev[0] = 32'h0;
        chk(32'(host_irq_n), 32'h0);
        rd(OFF_LINK_PHY_STAT, 32'h1);
        wr(OFF_LINK_PHY_STAT, 32'h1);
        chk(32'(host_irq_n), 32'h1);
        rd(OFF_LINK_PHY_STAT, 32'h0);
        complete_run;
    end
endmodule // lic_top_tb

// *** verilog/lic_pkg.sv ***
// package for the link interrupt and node identity block
// assumes one 100 MHz clock domain and whole-quadlet register access
package lic_pkg;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFF_NODE_IDENTITY  = 12'h000;
    localparam logic [11:0] OFF_LINK_CONTROL   = 12'h004;
    localparam logic [11:0] OFF_GLOBAL_CSR     = 12'h008;
    localparam logic [11:0] OFF_LINK_PHY_STAT  = 12'h010;
    localparam logic [11:0] OFF_LINK_PHY_EN    = 12'h014;
    localparam logic [11:0] OFF_AV_TX_STAT     = 12'h018;
    localparam logic [11:0] OFF_AV_TX_EN       = 12'h01c;
    localparam logic [11:0] OFF_AV_RX_STAT     = 12'h020;
    localparam logic [11:0] OFF_AV_RX_EN       = 12'h024;
    localparam logic [11:0] OFF_ASYNC_STAT     = 12'h028;
    localparam logic [11:0] OFF_ASYNC_EN       = 12'h02c;

    // ==================================================================
    // sections and field layout
    localparam int          NUM_SECTIONS       = 4;
    localparam int          BUS_NUM_LSB        = 22;
    localparam int          NODE_NUM_LSB       = 16;
    localparam int          PART_CODE_LSB      = 8;
    localparam logic [9:0]  BUS_NUM_RESET      = 10'h3ff;
    localparam logic [5:0]  NODE_NUM_RESET     = 6'h3f;
    // identification values are arbitrary
    localparam logic [7:0]  PART_CODE          = 8'h5a;
    localparam logic [7:0]  REVISION_CODE      = 8'h0a;
    localparam logic [31:0] LINK_CONTROL_RESET = 32'h00000000;
    localparam logic [31:0] STATUS_RESET       = 32'h00000000;
    localparam logic [31:0] ENABLE_RESET       = 32'h00000000;
    localparam logic [31:0] RDATA_RESET        = 32'h00000000;

endpackage

// *** verilog/lic_top.sv ***
// link interrupt aggregation and node identity registers
// assumes a host port with whole-quadlet reads and writes, and a phy
// that pulses bus reset completion with the assigned node number
`timescale 1ns/1ns

module lic_top
    import lic_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // host register port, whole quadlets only
    input  wire logic [11:0]              reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [31:0]              reg_wdata,
    output logic      [31:0]              reg_rdata,
    // section events, one bit per status bit
    input  wire logic [31:0]              link_phy_event,
    input  wire logic [31:0]              av_transmit_event,
    input  wire logic [31:0]              av_receive_event,
    input  wire logic [31:0]              async_event,
    // phy bus reset completion
    input  wire logic                     bus_reset_done,
    input  wire logic [5:0]               phy_node_num,
    // link addressing and control
    output logic      [9:0]               bus_num,
    output logic      [5:0]               node_num,
    output logic      [31:0]              link_control,
    // host interrupt
    output logic                          host_irq_n
);

    // ==================================================================
    // address decode
    wire        hit_id    = (reg_addr == OFF_NODE_IDENTITY);
    wire        hit_ctl   = (reg_addr == OFF_LINK_CONTROL);
    wire        hit_glob  = (reg_addr == OFF_GLOBAL_CSR);
    wire [11:0] stat_off [NUM_SECTIONS] = '{OFF_LINK_PHY_STAT, OFF_AV_TX_STAT,
                                            OFF_AV_RX_STAT, OFF_ASYNC_STAT};
    wire [11:0] en_off   [NUM_SECTIONS] = '{OFF_LINK_PHY_EN, OFF_AV_TX_EN,
                                            OFF_AV_RX_EN, OFF_ASYNC_EN};
    wire [31:0] sec_event [NUM_SECTIONS] = '{link_phy_event, av_transmit_event,
                                             av_receive_event, async_event};

    // ==================================================================
    // section status and enable registers, one section instance each
    logic [31:0]             sec_status [NUM_SECTIONS];
    logic [31:0]             sec_enable [NUM_SECTIONS];
    logic [NUM_SECTIONS-1:0] summary;
    logic [NUM_SECTIONS-1:0] hit_stat;
    logic [NUM_SECTIONS-1:0] hit_en;

    genvar s;
    generate
        for (s = 0; s < NUM_SECTIONS; s++) begin : g_sec
            assign hit_stat[s] = (reg_addr == stat_off[s]);
            assign hit_en[s]   = (reg_addr == en_off[s]);
            lic_section #(
                .WIDTH     (32)
            ) i_lic_section (
                .clk       (clk),
                .rst       (rst),
                .clear_wr  (reg_wr && hit_stat[s]),
                .enable_wr (reg_wr && hit_en[s]),
                .wdata     (reg_wdata),
                .event_in  (sec_event[s]),
                .status    (sec_status[s]),
                .enable    (sec_enable[s]),
                .summary   (summary[s])
            );
        end
    endgenerate

    // ==================================================================
    // interrupt output
    assign host_irq_n = ~(|summary);

    // ==================================================================
    // node identity and link control
    // a bus reset completion wins over a host write in the same cycle,
    // so the number handed over by the phy is never lost to software
    wire         id_wr       = reg_wr && hit_id;
    wire         ctl_wr      = reg_wr && hit_ctl;
    wire  [9:0]  wr_bus_num  = reg_wdata[BUS_NUM_LSB +: 10];
    wire  [5:0]  wr_node_num = reg_wdata[NODE_NUM_LSB +: 6];
    logic [9:0]  next_bus_num;
    logic [5:0]  next_node_num;
    logic [31:0] next_link_control;

    always_comb begin
        next_bus_num      = bus_num;
        next_node_num     = node_num;
        next_link_control = link_control;
        if (id_wr) begin
            next_bus_num  = wr_bus_num;
            next_node_num = wr_node_num;
        end
        if (bus_reset_done) begin
            next_bus_num  = BUS_NUM_RESET;
            next_node_num = phy_node_num;
        end
        if (ctl_wr) begin
            next_link_control = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_num      <= BUS_NUM_RESET;
            node_num     <= NODE_NUM_RESET;
            link_control <= LINK_CONTROL_RESET;
        end else begin
            bus_num      <= next_bus_num;
            node_num     <= next_node_num;
            link_control <= next_link_control;
        end
    end

    // ==================================================================
    // read data sources; unmapped and reserved bits read zero
    wire  [31:0] id_word   = {bus_num, node_num, PART_CODE, REVISION_CODE};
    wire  [31:0] glob_word = {28'h0000000, summary};
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h00000000;
        if (hit_id) begin
            next_rdata = id_word;
        end else if (hit_ctl) begin
            next_rdata = link_control;
        end else if (hit_glob) begin
            next_rdata = glob_word;
        end
        for (int i = 0; i < NUM_SECTIONS; i++) begin
            if (hit_stat[i]) begin
                next_rdata = sec_status[i];
            end
            if (hit_en[i]) begin
                next_rdata = sec_enable[i];
            end
        end
    end

    // ==================================================================
    // read data register; holds the last value until the next read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= RDATA_RESET;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // lic_top

// ==================================================================
// one section: latched status bits, per-bit enables, one summary bit
module lic_section
    import lic_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // host writes decoded for this section
    input  wire logic             clear_wr,
    input  wire logic             enable_wr,
    input  wire logic [WIDTH-1:0] wdata,
    // events, one per status bit
    input  wire logic [WIDTH-1:0] event_in,
    // register contents and summary
    output logic      [WIDTH-1:0] status,
    output logic      [WIDTH-1:0] enable,
    output logic                  summary
);

    // ==================================================================
    // write one to clear; a new event wins over a clear in the same cycle
    wire [WIDTH-1:0] clr_mask    = clear_wr ? wdata : '0;
    wire [WIDTH-1:0] next_status = (status & ~clr_mask) | event_in;
    wire [WIDTH-1:0] next_enable = enable_wr ? wdata : enable;

    assign summary = |(status & enable);

    always_ff @(posedge clk) begin
        if (rst) begin
            status <= WIDTH'(STATUS_RESET);
            enable <= WIDTH'(ENABLE_RESET);
        end else begin
            status <= next_status;
            enable <= next_enable;
        end
    end

endmodule // lic_section
